// [pcih_cfg_regs.sv]
// Identification, command and status registers of the configuration header
`timescale 1ns/1ps
`default_nettype none
`include "pcih_consts.svh"
// How it works
// R01: Fixed maker code at offset zero, read-only
// R02: Fixed part code at offset two, read-only
// R03: Command register at four, resets to zero except the fixed master bit
// R04: Command bits fifteen to seven read zero
// R05: Parity response reads zero, errors ignored
// R06: Palette snoop bit fixed at zero
// R07: Write-invalidate bit zero, never issued
// R08: Special cycle bit zero, cycles ignored
// R09: Bus master bit always reads one
// R10: Memory enable gates memory space response
// R11: I/O enable gates I/O space response
// R12: Status at six, resets 02B0, abort flags
// R13: Status shows target select timing class
// R14: Writing one clears, zero leaves bit
// R15: Select timing field reads binary 01
// R16: Host uses Type 0 config cycles only
// R17: Reserved command bits read zero always
module pcih_cfg_regs
  import pcih_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire pcih_cfg_t cfg_i,
  input wire pcih_evt_t evt_i,
  output logic [31:0] rdata_o,
  output logic mem_decode_en_o,
  output logic io_decode_en_o,
  output logic master_en_o,
  output logic mwi_allowed_o,
  output logic special_cycle_en_o
);
  // Writable command bits
  logic mem_en_r;
  logic io_en_r;
  // Sticky status flags
  logic tabort_q;
  logic mabort_q;
  logic syserr_q;
  // Word-aligned decode
  logic hit_w0;
  logic hit_w1;
  // Command write through byte lane 0
  logic cmd_lane_wr;
  // Status write through byte lane 3
  logic sts_lane_wr;
  // Per-flag write-one-to-clear strobes
  logic tabort_clr;
  logic mabort_clr;
  logic syserr_clr;
  // Assembled register images
  logic [15:0] cmd_val;
  logic [15:0] sts_val;
  // Reset images, sliced per bit so no bit is dropped by a shift
  localparam logic [15:0] CMD_RST = `PCIH_CMD_RST;
  localparam logic [15:0] STS_RST = `PCIH_STS_RST;

  // Word at offset zero or four
  function automatic logic word_hit(input logic [7:0] off, input logic [7:0] base);
    word_hit = (off[7:2] == base[7:2]);
  endfunction : word_hit

  // Clear strobe for the status bit at pos; only a one in that bit clears
  function automatic logic clear_hit(input logic lane_wr, input logic [31:0] wdata,
                                     input int pos);
    clear_hit = lane_wr && wdata[16 + pos];
  endfunction : clear_hit

  // R16: Type 0 access assumed; offset low bits are ignored
  assign hit_w0 = word_hit(cfg_i.off, `PCIH_OFF_MAKER);
  assign hit_w1 = word_hit(cfg_i.off, `PCIH_OFF_CMD);

  // Byte lanes that reach the writable and clearable bits
  // Lanes 1 and 2 carry only fixed bits, so they decode to nothing
  assign cmd_lane_wr = cfg_i.wr && hit_w1 && cfg_i.be[0];
  assign sts_lane_wr = cfg_i.wr && hit_w1 && cfg_i.be[3];

  // R14: one clears, zero leaves the flag alone
  assign tabort_clr = clear_hit(sts_lane_wr, cfg_i.wdata, `PCIH_STS_TABORT);
  assign mabort_clr = clear_hit(sts_lane_wr, cfg_i.wdata, `PCIH_STS_MABORT);
  assign syserr_clr = clear_hit(sts_lane_wr, cfg_i.wdata, `PCIH_STS_SYSERR);

  // Memory enable, written through byte lane 0
  // R10: memory space enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_en_r <= CMD_RST[`PCIH_CMD_MEM];
    end else if (cmd_lane_wr) begin
      mem_en_r <= cfg_i.wdata[`PCIH_CMD_MEM];
    end
  end

  // I/O enable, same lane
  // Kept apart from the memory enable so each bit has its own process
  // R11: io space enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      io_en_r <= CMD_RST[`PCIH_CMD_IO];
    end else if (cmd_lane_wr) begin
      io_en_r <= cfg_i.wdata[`PCIH_CMD_IO];
    end
  end

  // Command image; all other bits are constants so writes cannot reach them
  // R03: reset value zero except fixed master bit
  // R04: bits 15..7 tie to zero
  // R05: parity response zero
  // R06: palette snoop zero
  // R07: write invalidate zero
  // R08: special cycle zero
  // R09: bus master reads one
  // R17: reserved bits zero
  always_comb begin
    cmd_val = 16'h0000;
    cmd_val[`PCIH_CMD_MASTER] = 1'b1;
    cmd_val[`PCIH_CMD_MEM] = mem_en_r;
    cmd_val[`PCIH_CMD_IO] = io_en_r;
  end

  // Clears come from byte lane 3 (status high byte)
  // R14: write one clears
  pcih_sts_bit u_tabort (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(evt_i.tgt_abort),
    .clr_i(tabort_clr),
    .q_o(tabort_q)
  );
  pcih_sts_bit u_mabort (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(evt_i.mst_abort),
    .clr_i(mabort_clr),
    .q_o(mabort_q)
  );
  pcih_sts_bit u_syserr (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(evt_i.sys_err),
    .clr_i(syserr_clr),
    .q_o(syserr_q)
  );

  // Status image: fixed bits plus sticky flags
  // R12: status reset 02B0
  // R13: select timing shown
  // R15: timing field 01
  always_comb begin
    sts_val = `PCIH_STS_FIXED;
    sts_val[10:9] = `PCIH_SEL_TIMING;
    sts_val[`PCIH_STS_TABORT] = tabort_q;
    sts_val[`PCIH_STS_MABORT] = mabort_q;
    sts_val[`PCIH_STS_SYSERR] = syserr_q;
  end

  // Registered read data; unmapped offsets read zero
  // R01: maker code fixed
  // R02: part code fixed
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (cfg_i.rd && hit_w0) begin
      rdata_o <= {`PCIH_PART_CODE, `PCIH_MAKER_CODE};
    end else if (cfg_i.rd && hit_w1) begin
      rdata_o <= {sts_val, cmd_val};
    end else if (cfg_i.rd) begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Decode gates for the rest of the device
  assign mem_decode_en_o = mem_en_r;
  assign io_decode_en_o = io_en_r;
  assign master_en_o = cmd_val[`PCIH_CMD_MASTER];
  assign mwi_allowed_o = cmd_val[4];
  assign special_cycle_en_o = cmd_val[3];

  // Memory enable follows a written value next cycle
  chk_mem_enable_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.wr && hit_w1 && cfg_i.be[0] |=> mem_decode_en_o == $past(cfg_i.wdata[1]))
    else $error("memory enable did not take written value"); // R10
  chk_io_enable_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.wr && hit_w1 && cfg_i.be[0] |=> io_decode_en_o == $past(cfg_i.wdata[0]))
    else $error("io enable did not take written value"); // R11
  chk_cmd_fixed_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.rd && hit_w1 |=> rdata_o[15:2] == 14'h0001)
    else $error("command fixed bits wrong"); // R04
  chk_id_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.rd && hit_w0 |=> rdata_o == {`PCIH_PART_CODE, `PCIH_MAKER_CODE})
    else $error("identification read wrong"); // R01
  chk_timing_field: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.rd && hit_w1 |=> rdata_o[26:25] == 2'h1 && rdata_o[31] == 1'b0)
    else $error("select timing field wrong"); // R15
  chk_abort_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    evt_i.tgt_abort |=> tabort_q)
    else $error("target abort flag not set"); // R12
  chk_clear_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[29] && !evt_i.mst_abort |=> !mabort_q)
    else $error("write one did not clear"); // R14
  chk_clear_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mabort_q && !(cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[29]) |=> mabort_q)
    else $error("flag lost without write one"); // R14
  chk_reset_enables: assert property (@(posedge clk_i)
    sys_rst_i |=> !mem_decode_en_o && !io_decode_en_o)
    else $error("enables not zero after reset"); // R03

  // Checks on the command and identification words
  // Lanes other than 0 must leave the enables where they were
  chk_mem_lane_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    cfg_i.wr && hit_w1 && !cfg_i.be[0] |=> $stable(mem_decode_en_o))
    else $error("memory enable moved without lane 0");
  // Same for the I/O enable
  chk_io_lane_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
    cfg_i.wr && hit_w1 && !cfg_i.be[0] |=> $stable(io_decode_en_o))
    else $error("io enable moved without lane 0");
  // Writes to the identification word reach no state
  chk_id_write_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R02
    cfg_i.wr && hit_w0 |=> $stable(mem_decode_en_o) && $stable(io_decode_en_o))
    else $error("identification write changed state");
  // Part code in the upper half of word zero
  chk_part_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R02
    cfg_i.rd && hit_w0 |=> rdata_o[31:16] == `PCIH_PART_CODE)
    else $error("part code read wrong");
  // Enables read back in bits 1 and 0
  chk_cmd_enable_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    cfg_i.rd && hit_w1 |=> rdata_o[1:0] == $past({mem_decode_en_o, io_decode_en_o}))
    else $error("enables read back wrong");
  // Parity response reads zero, so parity errors go unreported
  chk_parity_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R05
    cfg_i.rd && hit_w1 |=> !rdata_o[6])
    else $error("parity response bit set");
  // Palette snooping never enabled
  chk_palette_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R06
    cfg_i.rd && hit_w1 |=> !rdata_o[5])
    else $error("palette snoop bit set");
  // Write-and-invalidate never offered
  chk_mwi_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R07
    cfg_i.rd && hit_w1 |=> !rdata_o[4])
    else $error("write invalidate bit set");
  // Special cycles never acted on
  chk_special_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R08
    cfg_i.rd && hit_w1 |=> !rdata_o[3])
    else $error("special cycle bit set");
  // Mastering always permitted
  chk_master_one: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R09
    cfg_i.rd && hit_w1 |=> rdata_o[2])
    else $error("bus master bit clear");
  // Reserved command bits read zero
  chk_reserved_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R17
    cfg_i.rd && hit_w1 |=> rdata_o[15:10] == 6'h00)
    else $error("reserved command bits set");
  // Unimplemented command bits read zero
  chk_unimpl_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R04
    cfg_i.rd && hit_w1 |=> rdata_o[9:7] == 3'h0)
    else $error("unimplemented command bits set");

  // Checks on the status word
  // Bits 11 to 0 and 15 never move; the flags sit in 14 to 12
  chk_status_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    cfg_i.rd && hit_w1 |=> rdata_o[27:16] == STS_RST[11:0] && !rdata_o[31])
    else $error("fixed status bits wrong");
  // Flags read back as they stood at the read edge
  chk_flag_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    cfg_i.rd && hit_w1 |=> rdata_o[30:28] == $past({syserr_q, mabort_q, tabort_q}))
    else $error("status flags read back wrong");
  // Master abort flag is sticky
  chk_mabort_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    evt_i.mst_abort |=> mabort_q)
    else $error("master abort flag not set");
  // System error flag is sticky too
  chk_syserr_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    evt_i.sys_err |=> syserr_q)
    else $error("system error flag not set");
  // A one clears unless the event repeats in that cycle
  chk_tabort_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[28] && !evt_i.tgt_abort |=> !tabort_q)
    else $error("target abort flag not cleared");
  // System error flag clears the same way
  chk_syserr_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[30] && !evt_i.sys_err |=> !syserr_q)
    else $error("system error flag not cleared");
  // Without a one in its bit a flag stays set
  chk_tabort_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    tabort_q && !(cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[28]) |=> tabort_q)
    else $error("target abort flag lost");
  // Same for system error
  chk_syserr_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    syserr_q && !(cfg_i.wr && hit_w1 && cfg_i.be[3] && cfg_i.wdata[30]) |=> syserr_q)
    else $error("system error flag lost");

  // Checks after reset
  // Flags start clear, so software sees no stale abort
  chk_reset_flags: assert property (@(posedge clk_i) // R12
    sys_rst_i |=> !tabort_q && !mabort_q && !syserr_q)
    else $error("status flags not clear after reset");
  // Read data starts at zero until the first read
  chk_reset_rdata: assert property (@(posedge clk_i) // R03
    sys_rst_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero after reset");
endmodule : pcih_cfg_regs
`default_nettype wire

// [pcih_consts.svh]
// Offsets, field positions, reset values and fixed codes of the configuration header
`ifndef PCIH_CONSTS_SVH
`define PCIH_CONSTS_SVH
`define PCIH_OFF_MAKER 8'h00
`define PCIH_OFF_PART 8'h02
`define PCIH_OFF_CMD 8'h04
`define PCIH_OFF_STS 8'h06
`define PCIH_MAKER_CODE 16'h1A2B
`define PCIH_PART_CODE 16'h3C4D
`define PCIH_CMD_RST 16'h0000
`define PCIH_STS_RST 16'h02B0
`define PCIH_CMD_IO 0
`define PCIH_CMD_MEM 1
`define PCIH_CMD_MASTER 2
`define PCIH_STS_TABORT 12
`define PCIH_STS_MABORT 13
`define PCIH_STS_SYSERR 14
`define PCIH_STS_FIXED 16'h02B0
`define PCIH_SEL_TIMING 2'h1
`endif

// [pcih_host_model.sv]
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pcih_host_model
  import pcih_pkg::*;
(
  input wire logic clk_i,
  output var pcih_cfg_t cfg_o
);
  // Idle at start, no strobes
  initial cfg_o = '0;
  task automatic cycle(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
    @(posedge clk_i) #1;
    cfg_o = '{rd: !w, wr: w, off: {a[7:2], 2'b00}, be: b, wdata: d};
    @(posedge clk_i) #1;
    // Released lines show garbage, not the old value
    cfg_o = '{rd: 1'b0, wr: 1'b0, off: ~a, be: ~b, wdata: ~d};
  endtask : cycle
endmodule : pcih_host_model
`default_nettype wire

// [pcih_pkg.sv]
// Types shared by the configuration header files
`default_nettype none
package pcih_pkg;
  // One configuration access from the bus front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] off;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcih_cfg_t;
  // Hardware events that set sticky status
  typedef struct packed {
    logic sys_err;
    logic mst_abort;
    logic tgt_abort;
  } pcih_evt_t;
endpackage : pcih_pkg
`default_nettype wire

// [pcih_sts_bit.sv]
// One sticky write-one-to-clear status bit
`timescale 1ns/1ps
`default_nettype none
module pcih_sts_bit (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule : pcih_sts_bit
`default_nettype wire

// [tb_pcih_cfg_regs.sv]
// Self-checking bench for the configuration header registers
`timescale 1ns/1ps
`default_nettype none
`include "pcih_consts.svh"
module tb_pcih_cfg_regs
  import pcih_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  pcih_cfg_t cfg;
  pcih_evt_t evt = '0;
  logic [31:0] rdata;
  logic mem_en, io_en, mst_en, mwi_en, spc_en;
  int fails = 0;
  int samples_checked = 0;
  localparam logic [31:0] ID = {`PCIH_PART_CODE, `PCIH_MAKER_CODE};
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  pcih_host_model pcih_host_model_inst (.clk_i(clk_i), .cfg_o(cfg));
  pcih_cfg_regs pcih_cfg_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg),
    .evt_i(evt), .rdata_o(rdata), .mem_decode_en_o(mem_en), .io_decode_en_o(io_en),
    .master_en_o(mst_en), .mwi_allowed_o(mwi_en), .special_cycle_en_o(spc_en));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : check
  // Read answer lands one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    pcih_host_model_inst.cycle(1'b0, a, 4'hF, 32'h0);
    v = rdata;
  endtask : rd
  // Read word one and compare, bus master bit masked
  task automatic rdc(input logic [31:0] e);
    logic [31:0] v;
    rd(`PCIH_OFF_CMD, v);
    check(v & 32'hFFFF_FFFB, e);
  endtask : rdc
  task automatic wr(input logic [3:0] b, input logic [31:0] d);
    pcih_host_model_inst.cycle(1'b1, `PCIH_OFF_CMD, b, d);
  endtask : wr
  task automatic t_reset;
    logic [31:0] v;
    rd(`PCIH_OFF_MAKER, v);
    check(v, ID); // fixed codes
    rdc(32'h02B0_0000); // reset values
    rd(`PCIH_OFF_STS, v);
    check({30'h0, v[26:25]}, 32'h1); // medium decode
    check({29'h0, mst_en, mwi_en, spc_en}, 32'h4); // fixed enables
    check({30'h0, mem_en, io_en}, 32'h0); // off after reset
    rd(8'h08, v);
    check(v, 32'h0); // unmapped reads zero
    pcih_host_model_inst.cycle(1'b1, `PCIH_OFF_MAKER, 4'hF, 32'hFFFF_FFFF);
    rd(`PCIH_OFF_PART, v);
    check(v, ID); // writes ignored
  endtask : t_reset
  task automatic t_cmd;
    wr(4'hF, 32'h0000_FFFF);
    rdc(32'h02B0_0003); // fixed zeros
    check({30'h0, mem_en, io_en}, 32'h3); // both on
    wr(4'h1, 32'h2);
    check({30'h0, mem_en, io_en}, 32'h2); // memory only
    wr(4'h1, 32'h1);
    wr(4'hE, 32'h0);
    check({30'h0, mem_en, io_en}, 32'h1); // lane off keeps
  endtask : t_cmd
  task automatic t_status;
    @(posedge clk_i) #1;
    evt = '1;
    @(posedge clk_i) #1;
    evt = '0;
    rdc(32'h72B0_0001); // abort flags set
    wr(4'h8, 32'h1000_0000);
    rdc(32'h62B0_0001); // one clears
    wr(4'h8, 32'h0);
    rdc(32'h62B0_0001); // zero keeps
    wr(4'h8, 32'h6000_0000);
    rdc(32'h02B0_0001); // rest cleared
  endtask : t_status
  // Event and clear in one cycle, then a second reset in mid-run
  task automatic t_rerun;
    evt = '1;
    wr(4'h8, 32'h7000_0000);
    evt = '0;
    rdc(32'h72B0_0001); // set beats clear
    @(posedge clk_i) #1;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    rdc(32'h02B0_0000); // reset again
    check({30'h0, mem_en, io_en}, 32'h0); // off again
  endtask : t_rerun
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // Watchdog, tests need about 60 cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    t_reset();
    t_cmd();
    t_status();
    t_rerun();
    test_done();
  end
endmodule : tb_pcih_cfg_regs
`default_nettype wire
